// >>> src/gosr_defines.svh
// Purpose: named constants of the gauge output and status registers
// Assumes: one aligned apb word per register, byte address = 4 x index
// Notes: definitions only
`ifndef GOSR_DEFINES_SVH
`define GOSR_DEFINES_SVH

// register indices
`define GOSR_IX_STATUS 8'h00
`define GOSR_IX_REP_CAP 8'h05
`define GOSR_IX_REP_SOC 8'h06
`define GOSR_IX_AGE 8'h07
`define GOSR_IX_FULL_REP 8'h10
`define GOSR_IX_TTE 8'h11
`define GOSR_IX_CELL_INTERNAL_RESISTANCE 8'h14
`define GOSR_IX_CYCLES 8'h17
`define GOSR_IX_TTF 8'h20
`define GOSR_IX_FULL_NOM 8'h23
`define GOSR_IX_FULL_CAP 8'h35
`define GOSR_IX_LOADED_OCV 8'h38
`define GOSR_IX_TEMP_COMP 8'h39
`define GOSR_IX_TIMER_LO 8'h3E
`define GOSR_IX_CONFIG 8'h60
`define GOSR_IX_CONTROL 8'h61
`define GOSR_IX_RIPPLE 8'hBC
`define GOSR_IX_TIMER_HI 8'hBE
`define GOSR_IX_AT_TTE 8'hDD
`define GOSR_IX_AT_SOC 8'hDE
`define GOSR_IX_AT_CAP 8'hDF

// status bit positions
`define GOSR_B_POR 1
`define GOSR_B_IMN 2
`define GOSR_B_BST 3
`define GOSR_B_IMX 6
`define GOSR_B_DSOC 7
`define GOSR_B_VMN 8
`define GOSR_B_TMN 9
`define GOSR_B_SMN 10
`define GOSR_B_BI 11
`define GOSR_B_VMX 12
`define GOSR_B_TMX 13
`define GOSR_B_SMX 14
`define GOSR_B_BR 15

// reset values
`define GOSR_STATUS_RST 16'h0002
`define GOSR_CELL_INTERNAL_RESISTANCE_RST 16'h0290
`define GOSR_ZERO16 16'h0000
`define GOSR_ALL16 16'hFFFF
// writable status bits; presence and spare bits excluded
`define GOSR_STATUS_WMASK 16'hFFC6
// age scale: 100 percent at 1/256 percent per lsb
`define GOSR_AGE_SCALE 32'h0000_6400
// time-to-empty scale, 5.625 s per lsb
`define GOSR_TTE_SHIFT 11
// largest step of reported capacity per update
`define GOSR_REP_STEP 16'h0040
// ripple filter shift and voltage-to-ripple gain
`define GOSR_RIPPLE_SHIFT 4
`define GOSR_RIPPLE_GAIN 3
// elapsed-time tick
`define GOSR_TICK_NS 175800000
`define GOSR_CLK_NS 20
`define GOSR_TICK_CYCLES (`GOSR_TICK_NS / `GOSR_CLK_NS)

`endif

// >>> src/gosr_pkg.sv
// Purpose: types of the gauge output and status registers
// Assumes: constants come from gosr_defines.svh
// Notes: none
`include "gosr_defines.svh"
package gosr_pkg;
    typedef enum logic [1:0] {
        gosr_src_reported,
        gosr_src_average,
        gosr_src_mixed,
        gosr_src_voltage
    } gosr_src_type;
endpackage

// >>> src/gosr_regs.sv
// Purpose: alert/status flags, elapsed time, cycles, health and output regs of a gauge
// Assumes: apb slave, zero wait states; gauge results arrive as ports with strobes
// Notes: status bits other than the presence bit are cleared by writing 0; a write of 1 leaves a bit alone
// Contract
// - power-on flag set by hardware or software reset, held until software clears it
// - low/high current flags set on reading below/above threshold; zero at reset
// - low/high voltage flags set on reading below/above threshold; zero at reset
// - low/high temperature flags set on reading below/above threshold; zero at reset
// - low/high charge flags set on selected charge below/above threshold
// - percent-step flag set on whole-percent crossing; host clears it
// - battery-absent bit is 1 while absent, 0 while present, 1 after reset until the filtered pin shows presence
// - insertion flag set on detected insertion, held until software clears it
// - removal flag set on detected removal, held until software clears it
// - low elapsed-time counts 175.8 ms steps from zero after reset
// - high elapsed-time extends low one to a 32-bit count
// - cycle register accumulates 1 percent steps, saturating at 655.35 cycles
// - health equals 100 percent times reported full capacity over design capacity
// - hypothetical charge reported at 1/256 percent per lsb
// - resistance register starts at 0x0290
// - ripple register filters ripple at 1.25mV/128 per lsb, starts at zero
// - time-to-empty derived from average capacity over average current
// - nominal full capacity updated on each relaxation event
// - reported full capacity updated at end of charge; remaining capacity slews
// - two-bit select picks the charge compared for alerts, default 00
`timescale 1ns/1ps
`default_nettype none
`include "gosr_defines.svh"

module gosr_regs #(
    parameter int unsigned TICK_CYCLES = `GOSR_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurements, one update per meas_valid pulse
    input wire logic meas_valid,
    input wire logic [15:0] current,
    input wire logic [15:0] average_current,
    input wire logic [15:0] cell_voltage,
    input wire logic [15:0] average_cell_voltage,
    input wire logic [15:0] temperature,
    // alert thresholds, min in [7:0], max in [15:8]
    input wire logic [15:0] current_alert_threshold,
    input wire logic [15:0] voltage_alert_threshold,
    input wire logic [15:0] temp_alert_threshold,
    input wire logic [15:0] charge_alert_threshold,
    // charge estimates from the gauging core
    input wire logic [15:0] reported_charge,
    input wire logic [15:0] average_charge,
    input wire logic [15:0] mixed_charge,
    input wire logic [15:0] voltage_charge,
    input wire logic [15:0] remaining_capacity,
    input wire logic [15:0] average_capacity,
    input wire logic [15:0] full_capacity,
    input wire logic [15:0] compensated_capacity,
    input wire logic [15:0] design_capacity,
    input wire logic [15:0] time_to_full_in,
    input wire logic [15:0] cell_resistance,
    input wire logic [15:0] hyp_time_to_empty,
    input wire logic [15:0] hyp_charge,
    input wire logic [15:0] hyp_capacity,
    // gauging events, one-cycle pulses
    input wire logic end_of_charge,
    input wire logic relaxation_event,
    input wire logic resistance_valid,
    // battery presence comparator on the aux analog input, asynchronous
    input wire logic aux_analog_input,
    // software power-on reset pulse to the gauging core
    output logic soft_por
);

    typedef struct packed {
        logic [2:0] present_sync;
        logic present;
        logic [15:0] status;
        logic [1:0] cfg_sel;
        logic [15:0] loaded_ocv;
        logic [15:0] temp_comp;
        logic [31:0] tick_cnt;
        logic [31:0] elapsed;
        logic [7:0] last_percent;
        logic half_cycle;
        logic [15:0] cycles;
        logic [15:0] age;
        logic [15:0] rep_cap;
        logic [15:0] full_rep;
        logic [15:0] full_nom;
        logic [15:0] full_cap;
        logic [15:0] time_to_empty;
        logic [15:0] time_to_full;
        logic [15:0] cell_internal_resistance;
        logic [15:0] ripple;
        logic [15:0] at_tte;
        logic [15:0] at_soc;
        logic [15:0] at_cap;
        logic por_pulse;
        logic [31:0] rdata;
    } gosr_state_type;

    gosr_state_type s_q;
    gosr_state_type s_d;

    logic wr;
    logic setup;
    logic hit;
    logic [7:0] idx;
    logic [15:0] rd_word;
    logic [15:0] sel_charge;
    logic [15:0] set_bits;
    logic [15:0] wr_status;
    logic [31:0] age_quot;
    logic [31:0] tte_quot;
    logic [15:0] discharge;
    logic [15:0] rip_sample;
    logic [15:0] rip_step;

    // threshold byte stands for the top byte of the word
    function automatic logic below_s(input logic [15:0] v, input logic [7:0] th);
        below_s = $signed(v) < $signed({th, 8'h00});
    endfunction

    function automatic logic above_s(input logic [15:0] v, input logic [7:0] th);
        above_s = $signed(v) > $signed({th, 8'h00});
    endfunction

    function automatic logic below_u(input logic [15:0] v, input logic [7:0] th);
        below_u = v < {th, 8'h00};
    endfunction

    function automatic logic above_u(input logic [15:0] v, input logic [7:0] th);
        above_u = v > {th, 8'h00};
    endfunction

    function automatic logic [15:0] sat16(input logic [31:0] v);
        sat16 = (v > 32'h0000_FFFF) ? `GOSR_ALL16 : v[15:0];
    endfunction

    assign idx = paddr[9:2];
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && hit;

    always_comb
    begin
        hit = (paddr[1:0] == 2'h0);
        rd_word = `GOSR_ZERO16;
        case (idx)
            `GOSR_IX_STATUS: rd_word = s_q.status;
            `GOSR_IX_REP_CAP: rd_word = s_q.rep_cap;
            `GOSR_IX_REP_SOC: rd_word = reported_charge;
            `GOSR_IX_AGE: rd_word = s_q.age;
            `GOSR_IX_FULL_REP: rd_word = s_q.full_rep;
            `GOSR_IX_TTE: rd_word = s_q.time_to_empty;
            `GOSR_IX_CELL_INTERNAL_RESISTANCE: rd_word = s_q.cell_internal_resistance;
            `GOSR_IX_CYCLES: rd_word = s_q.cycles;
            `GOSR_IX_TTF: rd_word = s_q.time_to_full;
            `GOSR_IX_FULL_NOM: rd_word = s_q.full_nom;
            `GOSR_IX_FULL_CAP: rd_word = s_q.full_cap;
            `GOSR_IX_LOADED_OCV: rd_word = s_q.loaded_ocv;
            `GOSR_IX_TEMP_COMP: rd_word = s_q.temp_comp;
            `GOSR_IX_TIMER_LO: rd_word = s_q.elapsed[15:0];
            `GOSR_IX_TIMER_HI: rd_word = s_q.elapsed[31:16];
            `GOSR_IX_CONFIG: rd_word = {14'h0000, s_q.cfg_sel};
            `GOSR_IX_CONTROL: rd_word = `GOSR_ZERO16;
            `GOSR_IX_RIPPLE: rd_word = s_q.ripple;
            `GOSR_IX_AT_TTE: rd_word = s_q.at_tte;
            // hypothetical charge already at 1/256 percent per lsb
            `GOSR_IX_AT_SOC: rd_word = s_q.at_soc;
            `GOSR_IX_AT_CAP: rd_word = s_q.at_cap;
            default: hit = 1'b0;
        endcase
    end

    always_comb
    begin
        case (gosr_pkg::gosr_src_type'(s_q.cfg_sel))
            gosr_pkg::gosr_src_reported: sel_charge = reported_charge;
            gosr_pkg::gosr_src_average: sel_charge = average_charge;
            gosr_pkg::gosr_src_mixed: sel_charge = mixed_charge;
            gosr_pkg::gosr_src_voltage: sel_charge = voltage_charge;
            default: sel_charge = reported_charge;
        endcase
    end

    // sources of status flags in this cycle
    always_comb
    begin
        set_bits = `GOSR_ZERO16;
        // comparisons only sampled on a measurement update
        if (meas_valid)
        begin
            set_bits[`GOSR_B_IMN] = below_s(current, current_alert_threshold[7:0]);
            set_bits[`GOSR_B_IMX] = above_s(current, current_alert_threshold[15:8]);
            set_bits[`GOSR_B_VMN] = below_u(cell_voltage, voltage_alert_threshold[7:0]);
            set_bits[`GOSR_B_VMX] = above_u(cell_voltage, voltage_alert_threshold[15:8]);
            set_bits[`GOSR_B_TMN] = below_s(temperature, temp_alert_threshold[7:0]);
            set_bits[`GOSR_B_TMX] = above_s(temperature, temp_alert_threshold[15:8]);
            // charge alerts on the selected estimate
            set_bits[`GOSR_B_SMN] = below_u(sel_charge, charge_alert_threshold[7:0]);
            set_bits[`GOSR_B_SMX] = above_u(sel_charge, charge_alert_threshold[15:8]);
            set_bits[`GOSR_B_DSOC] = reported_charge[15:8] != s_q.last_percent;
        end
        set_bits[`GOSR_B_BI] = s_q.present_sync[2] && s_q.present_sync[1] && !s_q.present;
        set_bits[`GOSR_B_BR] = !s_q.present_sync[2] && s_q.present;
    end

    // division is combinational; results only captured on update strobes
    always_comb
    begin
        age_quot = 32'h0000_0000;
        if (design_capacity != `GOSR_ZERO16)
        begin
            age_quot = ({16'h0000, s_q.full_rep} * `GOSR_AGE_SCALE) / {16'h0000, design_capacity};
        end
        discharge = 16'(-$signed(average_current));
        tte_quot = {16'h0000, `GOSR_ALL16};
        if ($signed(average_current) < 0)
        begin
            tte_quot = ({16'h0000, average_capacity} << `GOSR_TTE_SHIFT) / {16'h0000, discharge};
        end
        rip_sample = cell_voltage - average_cell_voltage;
        if ($signed(rip_sample) < 0)
        begin
            rip_sample = 16'(-$signed(rip_sample));
        end
        rip_sample = sat16({16'h0000, rip_sample} << `GOSR_RIPPLE_GAIN);
        rip_step = `GOSR_ZERO16;
        if (rip_sample > s_q.ripple)
        begin
            rip_step = (rip_sample - s_q.ripple) >> `GOSR_RIPPLE_SHIFT;
        end
    end

    assign wr_status = pwdata[15:0] | ~`GOSR_STATUS_WMASK;

    always_comb
    begin
        s_d = s_q;
        s_d.por_pulse = 1'b0;

        // presence pin: third flop agreeing with second marks a change
        s_d.present_sync = {s_q.present_sync[1:0], aux_analog_input};
        if (s_q.present_sync[2] == s_q.present_sync[1])
        begin
            s_d.present = s_q.present_sync[2];
        end

        // software clears by writing 0; a flag raised in the same cycle survives
        if (wr && idx == `GOSR_IX_STATUS)
        begin
            s_d.status = s_q.status & wr_status;
        end
        s_d.status = s_d.status | (set_bits & `GOSR_STATUS_WMASK);
        // presence bit follows the filtered pin
        s_d.status[`GOSR_B_BST] = !s_d.present;
        if (meas_valid)
        begin
            s_d.last_percent = reported_charge[15:8];
        end

        if (wr && idx == `GOSR_IX_CONFIG)
        begin
            s_d.cfg_sel = pwdata[1:0];
        end
        if (wr && idx == `GOSR_IX_LOADED_OCV)
        begin
            s_d.loaded_ocv = pwdata[15:0];
        end
        if (wr && idx == `GOSR_IX_TEMP_COMP)
        begin
            s_d.temp_comp = pwdata[15:0];
        end

        // tick counter, one step per 175.8 ms
        if (s_q.tick_cnt >= TICK_CYCLES - 1)
        begin
            s_d.tick_cnt = 32'h0000_0000;
            // low word carries into the high word as one 32-bit count
            s_d.elapsed = s_q.elapsed + 32'h0000_0001;
        end
        else
        begin
            s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
        end

        // two percent crossings count one percent of a full cycle
        if (set_bits[`GOSR_B_DSOC])
        begin
            s_d.half_cycle = !s_q.half_cycle;
            if (s_q.half_cycle && s_q.cycles != `GOSR_ALL16)
            begin
                s_d.cycles = s_q.cycles + 16'h0001;
            end
        end

        if (meas_valid)
        begin
            // health from reported full over design capacity
            s_d.age = sat16(age_quot);
            // average capacity over filtered discharge current
            s_d.time_to_empty = sat16(tte_quot);
            if (remaining_capacity > s_q.rep_cap + `GOSR_REP_STEP)
            begin
                s_d.rep_cap = s_q.rep_cap + `GOSR_REP_STEP;
            end
            else if (remaining_capacity + `GOSR_REP_STEP < s_q.rep_cap)
            begin
                s_d.rep_cap = s_q.rep_cap - `GOSR_REP_STEP;
            end
            else
            begin
                s_d.rep_cap = remaining_capacity;
            end
            if (rip_sample > s_q.ripple)
            begin
                s_d.ripple = s_q.ripple + rip_step;
            end
            else
            begin
                s_d.ripple = s_q.ripple - (s_q.ripple >> `GOSR_RIPPLE_SHIFT);
            end
            s_d.full_cap = compensated_capacity;
            s_d.time_to_full = time_to_full_in;
            s_d.at_tte = hyp_time_to_empty;
            s_d.at_soc = hyp_charge;
            s_d.at_cap = hyp_capacity;
        end
        // reported full capacity only moves at end of charge
        if (end_of_charge)
        begin
            s_d.full_rep = full_capacity;
        end
        // nominal capacity only moves on relaxation
        if (relaxation_event)
        begin
            s_d.full_nom = full_capacity;
        end
        // resistance held until the core posts a new value or a software reset reloads 0x0290
        if (resistance_valid)
        begin
            s_d.cell_internal_resistance = cell_resistance;
        end

        // latch read data at setup so it stands through access
        if (setup)
        begin
            s_d.rdata = {16'h0000, rd_word};
        end

        if (wr && idx == `GOSR_IX_CONTROL && pwdata[0])
        begin
            s_d.por_pulse = 1'b1;
            s_d.status = `GOSR_STATUS_RST;
            s_d.status[`GOSR_B_BST] = !s_d.present;
            s_d.tick_cnt = 32'h0000_0000;
            s_d.elapsed = 32'h0000_0000;
            s_d.ripple = `GOSR_ZERO16;
            s_d.cell_internal_resistance = `GOSR_CELL_INTERNAL_RESISTANCE_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
            // hardware reset leaves the power-on flag set
            s_q.status <= `GOSR_STATUS_RST;
            s_q.cell_internal_resistance <= `GOSR_CELL_INTERNAL_RESISTANCE_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // zero wait states; unmapped or misaligned accesses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = s_q.rdata;
    assign soft_por = s_q.por_pulse;

endmodule
`default_nettype wire

// >>> bench/gosr_regs_chk.sv
// Purpose: port-level checks of the gauge status register block
// Assumes: zero-wait apb, read data latched at setup
// Notes: presence judged after 7 settled cycles
`timescale 1ns/1ps
`default_nettype none
module gosr_regs_chk #(
    parameter int unsigned TICK_CYCLES = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // measurements
    input wire logic meas_valid,
    input wire logic [15:0] current,
    input wire logic [15:0] cell_voltage,
    input wire logic [15:0] current_alert_threshold,
    input wire logic [15:0] voltage_alert_threshold,
    input wire logic [15:0] reported_charge,
    // presence and software reset
    input wire logic aux_analog_input,
    input wire logic soft_por
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic status_rd;
    logic [2:0] absent_q;
    logic [2:0] present_q;
    logic [7:0] pct_ref_q;
    assign status_rd = psel && !penable && !pwrite && (paddr == 10'h000);
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            absent_q <= 3'h0;
            present_q <= 3'h0;
            pct_ref_q <= 8'h00;
        end
        else
        begin
            absent_q <= aux_analog_input ? 3'h0 : absent_q + 3'(absent_q != 3'h7);
            present_q <= !aux_analog_input ? 3'h0 : present_q + 3'(present_q != 3'h7);
            pct_ref_q <= meas_valid ? reported_charge[15:8] : pct_ref_q;
        end
    end
    a_soft_por_pulse: assert property (soft_por |=> !soft_por)
        else $error("por pulse long");
    a_soft_por_cause: assert property (psel && penable && pwrite && paddr == 10'h184
        && pwdata[0] |-> ##[1:2] soft_por) else $error("por pulse missing");
    a_status_spare_zero: assert property (status_rd |=> prdata[31:16] == 16'h0000
        && prdata[5:4] == 2'b00 && !prdata[0]) else $error("spare bits set");
    a_current_low_flag: assert property ((meas_valid && ($signed(current) <
        $signed({current_alert_threshold[7:0], 8'h00}))) ##1 status_rd |=> prdata[2])
        else $error("no low current");
    a_volt_high_flag: assert property ((meas_valid && cell_voltage >
        {voltage_alert_threshold[15:8], 8'h00}) ##1 status_rd |=> prdata[12])
        else $error("no high voltage");
    a_absent_status: assert property (absent_q == 3'h7 && status_rd |=> prdata[3])
        else $error("absent bit low");
    a_present_status: assert property (present_q == 3'h7 && status_rd |=> !prdata[3])
        else $error("absent bit high");
    a_percent_flag: assert property ((meas_valid && reported_charge[15:8] != pct_ref_q)
        ##1 status_rd |=> prdata[7]) else $error("no percent step");
endmodule
bind gosr_regs gosr_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .meas_valid(meas_valid),
    .current(current), .cell_voltage(cell_voltage),
    .current_alert_threshold(current_alert_threshold),
    .voltage_alert_threshold(voltage_alert_threshold), .reported_charge(reported_charge),
    .aux_analog_input(aux_analog_input), .soft_por(soft_por)
);
`default_nettype wire

// >>> bench/gosr_cell_model.sv
// Purpose: behavioural cell and sense resistor feeding the register block
// Assumes: one update per trig
// Notes: mode 0 nominal, 1 all low, 2 all high, 4..7 one charge estimate low
`timescale 1ns/1ps
`default_nettype none
module gosr_cell_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // bench control
    input wire logic trig,
    input wire logic [2:0] mode,
    input wire logic present,
    // measurement update
    output logic meas_valid,
    output logic [15:0] current,
    output logic [15:0] average_current,
    output logic [15:0] cell_voltage,
    output logic [15:0] average_cell_voltage,
    output logic [15:0] temperature,
    output logic [3:0][15:0] charges,
    // presence comparator
    output logic aux_analog_input
);
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            meas_valid <= 1'b0;
        else
            meas_valid <= trig;
    always_comb
    begin
        current = (mode == 3'h1) ? 16'hE000 : (mode == 3'h2) ? 16'h2000 : 16'h0000;
        average_current = current;
        cell_voltage = (mode == 3'h1) ? 16'h9000 : (mode == 3'h2) ? 16'hD000 : 16'hB000;
        average_cell_voltage = 16'hB000;
        temperature = (mode == 3'h1) ? 16'h0200 : (mode == 3'h2) ? 16'h4000 : 16'h1900;
        for (int k = 0; k < 4; k++)
            charges[k] = (mode == 3'h1 || mode == 3'(4 + k)) ? 16'h0800 :
                (mode == 3'h2) ? 16'h6000 : 16'h3000;
    end
    assign aux_analog_input = present;
endmodule
`default_nettype wire

// >>> bench/tb_gosr_regs.sv
// Purpose: self-checking bench of the gauge status and output registers
// Assumes: timer tick shortened to one clock
// Notes: alert thresholds tied at the instance
`timescale 1ns/1ps
`default_nettype none
module tb_gosr_regs;
    localparam logic [31:0] MSK = 32'h0000FFCE;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    localparam logic [7:0] OIX [12] = '{8'h10, 8'h23, 8'h07, 8'h14, 8'hDE, 8'hDF, 8'h11,
        8'h05, 8'h17, 8'h35, 8'h20, 8'hDD};
    localparam logic [31:0] OVAL [12] = '{32'h0708, 32'h0708, 32'h5A00, 32'h1006, 32'h1008,
        32'h1009, 32'h0040, 32'h0180, 32'h0002, 32'h1003, 32'h1005, 32'h1007};
    localparam logic [2:0] MV [6] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h0, 3'h1};
    localparam logic [31:0] MX [6] = '{32'h0080, 32'h0784, 32'h70C0, 32'h7040, 32'h0080,
        32'h0784};
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic trig = 1'b0, present = 1'b1;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] mode = 3'h0, ev = 3'h0;
    logic [15:0] gv [10];
    logic [31:0] prdata, t0, t1;
    logic pready, pslverr, soft_por, meas_valid, aux_analog_input, err;
    logic [15:0] current, average_current, cell_voltage, average_cell_voltage, temperature;
    logic [3:0][15:0] charges;
    int err_count = 0;
    int cmp_count = 0;
    always #10 clk = ~clk;
    gosr_cell_model u_cell (
        .clk(clk), .rst_b(rst_b), .trig(trig), .mode(mode), .present(present),
        .meas_valid(meas_valid), .current(current), .average_current(average_current),
        .cell_voltage(cell_voltage), .average_cell_voltage(average_cell_voltage),
        .temperature(temperature), .charges(charges), .aux_analog_input(aux_analog_input)
    );
    gosr_regs #(.TICK_CYCLES(1)) DUT (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas_valid(meas_valid), .current(current), .average_current(average_current),
        .cell_voltage(cell_voltage), .average_cell_voltage(average_cell_voltage),
        .temperature(temperature), .current_alert_threshold(16'h10F0),
        .voltage_alert_threshold(16'hC0A0), .temp_alert_threshold(16'h3005),
        .charge_alert_threshold(16'h5010), .reported_charge(charges[0]),
        .average_charge(charges[1]), .mixed_charge(charges[2]), .voltage_charge(charges[3]),
        .remaining_capacity(gv[0]), .average_capacity(gv[1]), .full_capacity(gv[2]),
        .compensated_capacity(gv[3]), .design_capacity(gv[4]), .time_to_full_in(gv[5]),
        .cell_resistance(gv[6]), .hyp_time_to_empty(gv[7]), .hyp_charge(gv[8]),
        .hyp_capacity(gv[9]), .end_of_charge(ev[0]), .relaxation_event(ev[1]),
        .resistance_valid(ev[2]), .aux_analog_input(aux_analog_input), .soft_por(soft_por)
    );
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until pready is high at an edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
        output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge clk);
        while (pready !== 1'b1 && ++n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            err_count++;
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
        apb(1'b1, idx, wd, t1, err);
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, idx, 16'h0000, t1, err);
        chk(t1 & m, exp);
    endtask
    task automatic meas(input logic [2:0] m);
        @(posedge clk);
        trig <= 1'b1;
        mode <= m;
        @(posedge clk);
        trig <= 1'b0;
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
    endtask
    initial
    begin
        for (int i = 0; i < 10; i++)
            gv[i] = 16'h1000 + 16'(i);
        gv[1] = 16'h0100;
        gv[2] = 16'h0708;
        gv[4] = 16'h07D0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        rchk(8'h00, 32'h0802, MSK);
        rchk(8'h14, 32'h0290, ALL);
        rchk(8'hBC, 32'h0000, ALL);
        rchk(8'hBE, 32'h0000, ALL);
        wr(8'h00, 16'h0000);
        rchk(8'h00, 32'h0000, MSK);
        wr(8'h38, 16'h1234);
        rchk(8'h38, 32'h1234, ALL);
        wr(8'h14, 16'h5555);
        rchk(8'h14, 32'h0290, ALL);
        apb(1'b0, 8'h01, 16'h0000, t0, err);
        chk({err, t0[30:0]}, 32'h80000000);
        for (int k = 0; k < 3; k++)
            pulse(k);
        for (int i = 0; i < 6; i++)
        begin
            meas(MV[i]);
            rchk(8'h00, MX[i], MSK);
            wr(8'h00, 16'h0000);
        end
        for (int i = 0; i < 12; i++)
            rchk(OIX[i], OVAL[i], ALL);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h60, 16'(k));
            for (int j = 0; j < 4; j++)
            begin
                meas(3'(4 + j));
                rchk(8'h00, (j == k) ? 32'h0400 : 32'h0000, 32'h0400);
                wr(8'h00, 16'h0000);
            end
        end
        @(posedge clk) present <= 1'b0;
        repeat (10) @(posedge clk);
        rchk(8'h00, 32'h8008, 32'h8808);
        wr(8'h00, 16'h0000);
        rchk(8'h00, 32'h0008, 32'h8808);
        @(posedge clk) present <= 1'b1;
        repeat (10) @(posedge clk);
        rchk(8'h00, 32'h0800, 32'h8808);
        wr(8'h00, 16'h0000);
        wr(8'h61, 16'h0001);
        rchk(8'h00, 32'h0002, MSK);
        rchk(8'h14, 32'h0290, ALL);
        apb(1'b0, 8'h3E, 16'h0000, t0, err);
        repeat (40) @(posedge clk);
        apb(1'b0, 8'h3E, 16'h0000, t1, err);
        chk(t1 - t0, 32'd43);
        repeat (65540) @(posedge clk);
        rchk(8'hBE, 32'h0001, ALL);
        final_report();
    end
endmodule
`default_nettype wire
